// ==== src/pfcsf_hyst.sv ====
/*
 * Hysteresis comparator: returns the next value of a held condition.
 * Assumes all inputs come from logic on the same clock; holds no state.
 */
`timescale 1ns/10ps
`default_nettype none

module pfcsf_hyst #(
    parameter int W = 13
) (
    input wire logic state_i,
    input wire logic [W-1:0] value_i,
    input wire logic [W:0] set_above_i,
    input wire logic [W:0] clr_below_i,
    output logic next_o
);

    logic [W:0] val_ext;

    assign val_ext = {1'b0, value_i};

    // Set checked first; a level in the band keeps the old state
    always_comb begin
        if (val_ext > set_above_i) begin
            next_o = 1'b1;
        end else if (val_ext < clr_below_i) begin
            next_o = 1'b0;
        end else begin
            next_o = state_i;
        end
    end

endmodule

`default_nettype wire

// ==== src/pfcsf_pkg.sv ====
/*
 * Constants for the setpoint and feature register bank of the PFC controller:
 * register offsets, field widths and positions, reset values and timing counts.
 * Assumes a single 50 MHz controller clock.
 */
package pfcsf_pkg;

    // ********************************************************************
    // Register offsets
    // ********************************************************************
    localparam logic [15:0] ADDR_VOUT_LL_LIGHT = 16'hFE46;
    localparam logic [15:0] ADDR_VOUT_LL_HEAVY = 16'hFE47;
    localparam logic [15:0] ADDR_VOUT_HL_LIGHT = 16'hFE48;
    localparam logic [15:0] ADDR_VOUT_HL_HEAVY = 16'hFE49;
    localparam logic [15:0] ADDR_VOUT_UPPER = 16'hFE4A;
    localparam logic [15:0] ADDR_SHL_THRESH = 16'hFE4B;
    localparam logic [15:0] ADDR_SYNC_DELAY = 16'hFE4C;
    localparam logic [15:0] ADDR_SHL_HYS = 16'hFE4D;
    localparam logic [15:0] ADDR_POWER_MODE_HYSTERESIS = 16'hFE4E;
    localparam logic [15:0] ADDR_FEATURES = 16'hFE4F;
    localparam logic [15:0] ADDR_OV_HYS = 16'hFE50;

    // ********************************************************************
    // Field widths
    // ********************************************************************
    localparam int SETPOINT_W = 11;
    localparam int POWER_W = 13;
    localparam int HYS_W = 8;
    localparam int SYNC_W = 16;
    localparam int FEAT_W = 8;
    localparam int REG_W = 16;

    // ********************************************************************
    // Feature enable bit positions
    // ********************************************************************
    localparam int FEAT_FEEDFWD = 6;
    localparam int FEAT_LL_FILTER = 5;
    localparam int FEAT_PHASE_SHED = 4;
    localparam int FEAT_SMART_FSW = 3;
    localparam int FEAT_SMART_VOUT = 2;
    localparam int FEAT_PWM_SYNC = 1;
    localparam int FEAT_DITHER = 0;
    localparam logic [7:0] FEAT_WR_MASK = 8'h7F;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [10:0] RST_SETPOINT = 11'h000;
    localparam logic [15:0] RST_SYNC_DELAY = 16'h0000;
    localparam logic [7:0] RST_HYS = 8'h00;
    localparam logic [7:0] RST_FEATURES = 8'h00;

    // ********************************************************************
    // Overvoltage fault action codes
    // ********************************************************************
    localparam logic [1:0] OV_ACTION_IGNORE = 2'h0;
    localparam logic [1:0] OV_ACTION_DISABLE = 2'h2;

    // ********************************************************************
    // Timing
    // ********************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int SYNC_LSB_NS = 40;
    localparam int SYNC_CYC_PER_LSB = (SYNC_LSB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_CNT_W = 18;

    // ********************************************************************
    // Register index after address decode
    // ********************************************************************
    typedef enum logic [3:0] {
        IDX_LL_LIGHT,
        IDX_LL_HEAVY,
        IDX_HL_LIGHT,
        IDX_HL_HEAVY,
        IDX_UPPER,
        IDX_SHL_THRESH,
        IDX_SYNC_DELAY,
        IDX_SHL_HYS,
        IDX_POWER_MODE_HYSTERESIS,
        IDX_FEATURES,
        IDX_OV_HYS,
        IDX_NONE
    } pfcsf_idx_t;

endpackage

// ==== src/pfcsf_regs.sv ====
/*
 * Setpoint and feature register bank of the PFC controller: eleven registers
 * on the management register port, output voltage setpoint selection by power
 * mode and line class, super high line override, overvoltage re-enable and the
 * delayed PWM start after the external sync reference.
 * Assumes power, line class, voltage and fault inputs come from logic on
 * mclk_i; only sync_ref_i is asynchronous.
 */
`timescale 1ns/10ps
`default_nettype none

module pfcsf_regs (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    output logic reg_rd_valid_o,
    input wire logic [12:0] input_power_i,
    input wire logic [12:0] low_power_threshold_i,
    input wire logic [12:0] high_power_threshold_i,
    input wire logic high_line_i,
    input wire logic [10:0] ac_input_voltage_i,
    input wire logic [10:0] vout_command_i,
    input wire logic [10:0] vout_sense_i,
    input wire logic [10:0] overvoltage_fault_limit_i,
    input wire logic [1:0] overvoltage_fault_action_i,
    input wire logic ov_fault_i,
    input wire logic sync_ref_i,
    output logic [10:0] vout_target_o,
    output logic low_power_mode_o,
    output logic super_high_line_o,
    output logic ov_shutdown_o,
    output logic pwm_sync_start_o,
    output logic feedforward_en_o,
    output logic light_load_filter_en_o,
    output logic phase_shed_en_o,
    output logic smart_fsw_en_o,
    output logic smart_vout_en_o,
    output logic pwm_sync_en_o,
    output logic dither_en_o
);

    // ********************************************************************
    // State
    // ********************************************************************
    typedef struct packed {
        logic [10:0] lowline_lightload_setpoint;
        logic [10:0] lowline_heavyload_setpoint;
        logic [10:0] highline_lightload_setpoint;
        logic [10:0] highline_heavyload_setpoint;
        logic [10:0] upper_limit_setpoint;
        logic [10:0] shl_threshold;
        logic [15:0] sync_delay;
        logic [7:0] shl_hys;
        logic [7:0] power_mode_hysteresis;
        logic [7:0] features;
        logic [7:0] ov_hys;
        logic sync_s1;
        logic sync_s2;
        logic sync_s3;
        logic sync_lvl;
        logic sync_armed;
        logic [pfcsf_pkg::SYNC_CNT_W-1:0] sync_cnt;
        logic sync_pulse;
        logic low_power;
        logic shl_active;
        logic ov_shutdown;
        logic [10:0] vout_target;
        logic [15:0] rdata;
        logic rd_valid;
    } pfcsf_state_t;

    pfcsf_state_t st_r;
    pfcsf_state_t st_nxt;

    // ********************************************************************
    // Helpers
    // ********************************************************************
    function automatic pfcsf_pkg::pfcsf_idx_t pfcsf_decode(input logic [15:0] addr);
        pfcsf_pkg::pfcsf_idx_t idx;
        unique case (addr)
            pfcsf_pkg::ADDR_VOUT_LL_LIGHT: idx = pfcsf_pkg::IDX_LL_LIGHT;
            pfcsf_pkg::ADDR_VOUT_LL_HEAVY: idx = pfcsf_pkg::IDX_LL_HEAVY;
            pfcsf_pkg::ADDR_VOUT_HL_LIGHT: idx = pfcsf_pkg::IDX_HL_LIGHT;
            pfcsf_pkg::ADDR_VOUT_HL_HEAVY: idx = pfcsf_pkg::IDX_HL_HEAVY;
            pfcsf_pkg::ADDR_VOUT_UPPER: idx = pfcsf_pkg::IDX_UPPER;
            pfcsf_pkg::ADDR_SHL_THRESH: idx = pfcsf_pkg::IDX_SHL_THRESH;
            pfcsf_pkg::ADDR_SYNC_DELAY: idx = pfcsf_pkg::IDX_SYNC_DELAY;
            pfcsf_pkg::ADDR_SHL_HYS: idx = pfcsf_pkg::IDX_SHL_HYS;
            pfcsf_pkg::ADDR_POWER_MODE_HYSTERESIS: idx = pfcsf_pkg::IDX_POWER_MODE_HYSTERESIS;
            pfcsf_pkg::ADDR_FEATURES: idx = pfcsf_pkg::IDX_FEATURES;
            pfcsf_pkg::ADDR_OV_HYS: idx = pfcsf_pkg::IDX_OV_HYS;
            default: idx = pfcsf_pkg::IDX_NONE;
        endcase
        return idx;
    endfunction

    // Limit minus hysteresis, floored at zero so a large hysteresis cannot wrap
    function automatic logic [11:0] pfcsf_sat_sub(input logic [10:0] lim,
                                                  input logic [7:0] hys);
        logic [11:0] diff;
        diff = {1'b0, lim} - {4'h0, hys};
        if (diff[11]) begin
            diff = 12'h000;
        end
        return diff;
    endfunction

    // ********************************************************************
    // Thresholds and hysteresis comparators
    // ********************************************************************
    localparam int SYNC_CNT_W = pfcsf_pkg::SYNC_CNT_W;
    pfcsf_pkg::pfcsf_idx_t reg_idx;
    logic [13:0] low_exit_level;
    logic [13:0] high_enter_level;
    logic high_power_nxt;
    logic [11:0] shl_release_level;
    logic shl_nxt;
    logic [7:0] ov_hys_eff;
    logic [11:0] ov_release_level;
    logic ov_below_release;
    logic sync_edge;
    logic [pfcsf_pkg::SYNC_CNT_W-1:0] sync_load;
    logic [10:0] power_setpoint;

    assign reg_idx = pfcsf_decode(reg_addr_i);

    // Either exit condition leaves low power; the lower one wins
    assign low_exit_level = {1'b0, low_power_threshold_i} + {6'h00, st_r.power_mode_hysteresis};
    assign high_enter_level = ({1'b0, high_power_threshold_i} < low_exit_level)
        ? {1'b0, high_power_threshold_i} : low_exit_level;

    pfcsf_hyst #(.W(13)) u_power_mode (
        .state_i(~st_r.low_power),
        .value_i(input_power_i),
        .set_above_i(high_enter_level),
        .clr_below_i({1'b0, low_power_threshold_i}),
        .next_o(high_power_nxt)
    );

    assign shl_release_level = pfcsf_sat_sub(st_r.shl_threshold, st_r.shl_hys);

    pfcsf_hyst #(.W(11)) u_super_high_line (
        .state_i(st_r.shl_active),
        .value_i(ac_input_voltage_i),
        .set_above_i({1'b0, st_r.shl_threshold}),
        .clr_below_i(shl_release_level),
        .next_o(shl_nxt)
    );

    // Other fault actions leave the limit itself as release level
    assign ov_hys_eff = (overvoltage_fault_action_i == pfcsf_pkg::OV_ACTION_DISABLE)
        ? st_r.ov_hys : pfcsf_pkg::RST_HYS;

    assign ov_release_level = pfcsf_sat_sub(overvoltage_fault_limit_i, ov_hys_eff);
    assign ov_below_release = {1'b0, vout_sense_i} < ov_release_level;

    // Only the filtered level is edge-detected, never the first stage
    assign sync_edge = st_r.sync_s2 & st_r.sync_s3 & ~st_r.sync_lvl;
    assign sync_load = SYNC_CNT_W'(st_r.sync_delay) * SYNC_CNT_W'(pfcsf_pkg::SYNC_CYC_PER_LSB);

    always_comb begin
        if (~st_r.low_power) begin
            power_setpoint = high_line_i ? st_r.highline_heavyload_setpoint
                                         : st_r.lowline_heavyload_setpoint;
        end else begin
            power_setpoint = high_line_i ? st_r.highline_lightload_setpoint
                                         : st_r.lowline_lightload_setpoint;
        end
    end

    // ********************************************************************
    // Next state
    // ********************************************************************
    always_comb begin
        st_nxt = st_r;

        // Register writes; reserved bits are dropped
        if (reg_wr_i) begin
            unique case (reg_idx)
                pfcsf_pkg::IDX_LL_LIGHT: begin
                    st_nxt.lowline_lightload_setpoint = reg_wdata_i[10:0];
                end
                pfcsf_pkg::IDX_LL_HEAVY: begin
                    st_nxt.lowline_heavyload_setpoint = reg_wdata_i[10:0];
                end
                pfcsf_pkg::IDX_HL_LIGHT: begin
                    st_nxt.highline_lightload_setpoint = reg_wdata_i[10:0];
                end
                pfcsf_pkg::IDX_HL_HEAVY: begin
                    st_nxt.highline_heavyload_setpoint = reg_wdata_i[10:0];
                end
                pfcsf_pkg::IDX_UPPER: begin
                    st_nxt.upper_limit_setpoint = reg_wdata_i[10:0];
                end
                pfcsf_pkg::IDX_SHL_THRESH: st_nxt.shl_threshold = reg_wdata_i[10:0];
                pfcsf_pkg::IDX_SYNC_DELAY: st_nxt.sync_delay = reg_wdata_i;
                pfcsf_pkg::IDX_SHL_HYS: st_nxt.shl_hys = reg_wdata_i[7:0];
                pfcsf_pkg::IDX_POWER_MODE_HYSTERESIS: st_nxt.power_mode_hysteresis = reg_wdata_i[7:0];
                pfcsf_pkg::IDX_FEATURES: begin
                    st_nxt.features = reg_wdata_i[7:0] & pfcsf_pkg::FEAT_WR_MASK;
                end
                pfcsf_pkg::IDX_OV_HYS: st_nxt.ov_hys = reg_wdata_i[7:0];
                pfcsf_pkg::IDX_NONE: begin
                end
            endcase
        end

        // Register reads; unmapped offsets answer zero
        st_nxt.rd_valid = reg_rd_i;
        if (reg_rd_i) begin
            unique case (reg_idx)
                pfcsf_pkg::IDX_LL_LIGHT: st_nxt.rdata = {5'h00, st_r.lowline_lightload_setpoint};
                pfcsf_pkg::IDX_LL_HEAVY: st_nxt.rdata = {5'h00, st_r.lowline_heavyload_setpoint};
                pfcsf_pkg::IDX_HL_LIGHT: st_nxt.rdata = {5'h00, st_r.highline_lightload_setpoint};
                pfcsf_pkg::IDX_HL_HEAVY: st_nxt.rdata = {5'h00, st_r.highline_heavyload_setpoint};
                pfcsf_pkg::IDX_UPPER: st_nxt.rdata = {5'h00, st_r.upper_limit_setpoint};
                pfcsf_pkg::IDX_SHL_THRESH: st_nxt.rdata = {5'h00, st_r.shl_threshold};
                pfcsf_pkg::IDX_SYNC_DELAY: st_nxt.rdata = st_r.sync_delay;
                pfcsf_pkg::IDX_SHL_HYS: st_nxt.rdata = {8'h00, st_r.shl_hys};
                pfcsf_pkg::IDX_POWER_MODE_HYSTERESIS: st_nxt.rdata = {8'h00, st_r.power_mode_hysteresis};
                pfcsf_pkg::IDX_FEATURES: st_nxt.rdata = {8'h00, st_r.features};
                pfcsf_pkg::IDX_OV_HYS: st_nxt.rdata = {8'h00, st_r.ov_hys};
                pfcsf_pkg::IDX_NONE: st_nxt.rdata = 16'h0000;
            endcase
        end

        // Power mode and override only track while smart output voltage is on
        if (st_r.features[pfcsf_pkg::FEAT_SMART_VOUT]) begin
            st_nxt.low_power = ~high_power_nxt;
            st_nxt.shl_active = shl_nxt;
            if (st_r.shl_active && !shl_nxt) begin
                st_nxt.low_power = 1'b0;
            end
        end else begin
            st_nxt.low_power = 1'b0;
            st_nxt.shl_active = 1'b0;
        end

        // Setpoint selection
        if (!st_r.features[pfcsf_pkg::FEAT_SMART_VOUT]) begin
            st_nxt.vout_target = vout_command_i;
        end else if (st_r.shl_active) begin
            st_nxt.vout_target = st_r.upper_limit_setpoint;
        end else begin
            st_nxt.vout_target = power_setpoint;
        end

        // Overvoltage shutdown; a new fault wins over the release
        if (ov_fault_i && overvoltage_fault_action_i != pfcsf_pkg::OV_ACTION_IGNORE) begin
            st_nxt.ov_shutdown = 1'b1;
        end else if (st_r.ov_shutdown && ov_below_release) begin
            st_nxt.ov_shutdown = 1'b0;
        end

        // Sync input filter: a change counts once stages two and three agree
        st_nxt.sync_s1 = sync_ref_i;
        st_nxt.sync_s2 = st_r.sync_s1;
        st_nxt.sync_s3 = st_r.sync_s2;
        if (st_r.sync_s2 == st_r.sync_s3) begin
            st_nxt.sync_lvl = st_r.sync_s3;
        end

        // Delay counter; an edge during a count restarts it
        st_nxt.sync_pulse = 1'b0;
        if (!st_r.features[pfcsf_pkg::FEAT_PWM_SYNC]) begin
            st_nxt.sync_armed = 1'b0;
            st_nxt.sync_cnt = '0;
        end else if (sync_edge) begin
            st_nxt.sync_armed = 1'b1;
            st_nxt.sync_cnt = sync_load;
        end else if (st_r.sync_armed) begin
            if (st_r.sync_cnt == '0) begin
                st_nxt.sync_pulse = 1'b1;
                st_nxt.sync_armed = 1'b0;
            end else begin
                st_nxt.sync_cnt = st_r.sync_cnt - SYNC_CNT_W'(1);
            end
        end
    end

    // ********************************************************************
    // Registers
    // ********************************************************************
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st_r <= '{
                lowline_lightload_setpoint: pfcsf_pkg::RST_SETPOINT,
                lowline_heavyload_setpoint: pfcsf_pkg::RST_SETPOINT,
                highline_lightload_setpoint: pfcsf_pkg::RST_SETPOINT,
                highline_heavyload_setpoint: pfcsf_pkg::RST_SETPOINT,
                upper_limit_setpoint: pfcsf_pkg::RST_SETPOINT,
                shl_threshold: pfcsf_pkg::RST_SETPOINT,
                sync_delay: pfcsf_pkg::RST_SYNC_DELAY,
                shl_hys: pfcsf_pkg::RST_HYS,
                power_mode_hysteresis: pfcsf_pkg::RST_HYS,
                features: pfcsf_pkg::RST_FEATURES,
                ov_hys: pfcsf_pkg::RST_HYS,
                default: '0
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    // ********************************************************************
    // Outputs
    // ********************************************************************
    assign reg_rdata_o = st_r.rdata;
    assign reg_rd_valid_o = st_r.rd_valid;
    assign vout_target_o = st_r.vout_target;
    assign low_power_mode_o = st_r.low_power;
    assign super_high_line_o = st_r.shl_active;
    assign ov_shutdown_o = st_r.ov_shutdown;
    assign pwm_sync_start_o = st_r.sync_pulse;
    assign feedforward_en_o = st_r.features[pfcsf_pkg::FEAT_FEEDFWD];
    assign light_load_filter_en_o = st_r.features[pfcsf_pkg::FEAT_LL_FILTER];
    assign phase_shed_en_o = st_r.features[pfcsf_pkg::FEAT_PHASE_SHED];
    assign smart_fsw_en_o = st_r.features[pfcsf_pkg::FEAT_SMART_FSW];
    assign smart_vout_en_o = st_r.features[pfcsf_pkg::FEAT_SMART_VOUT];
    assign pwm_sync_en_o = st_r.features[pfcsf_pkg::FEAT_PWM_SYNC];
    assign dither_en_o = st_r.features[pfcsf_pkg::FEAT_DITHER];

endmodule

`default_nettype wire

// ==== verif/pfc_setpoint_feature_regs_tb_top.sv ====
/* Self-checking bench for the PFC setpoint and feature register bank.
   Assumes the bank alone; measurement inputs are driven by the bench. */
`timescale 1ns/10ps
`default_nettype none
module pfc_setpoint_feature_regs_tb_top;
    typedef struct packed {logic hl; logic [12:0] pw; logic [10:0] tgt; logic lp;} pfcsf_row_t;
    logic mclk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic high_line_i = 1'b0, ov_fault_i = 1'b0, sync_ref_i = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000, reg_wdata_i = 16'h0000, reg_rdata_o;
    logic [12:0] input_power_i = 13'h0000, low_power_threshold_i = 13'h0064;
    logic [12:0] high_power_threshold_i = 13'h0190;
    logic [10:0] ac_input_voltage_i = 11'h000, vout_command_i = 11'h0AB, vout_target_o;
    logic [10:0] vout_sense_i = 11'h210, overvoltage_fault_limit_i = 11'h200;
    logic [1:0] overvoltage_fault_action_i = 2'h0;
    logic reg_rd_valid_o, low_power_mode_o, super_high_line_o, ov_shutdown_o, pwm_sync_start_o;
    logic feedforward_en_o, light_load_filter_en_o, phase_shed_en_o, smart_fsw_en_o;
    logic smart_vout_en_o, pwm_sync_en_o, dither_en_o;
    logic [6:0] feats;
    int n_fail = 0, samples_checked = 0, n0, n3;
    // Power hysteresis 0x20 puts the low power exit at 0x84
    pfcsf_row_t rows [8] = '{{1'b0, 13'h0032, 11'h111, 1'b1}, {1'b1, 13'h0032, 11'h333, 1'b1},
        {1'b1, 13'h006E, 11'h333, 1'b1}, {1'b1, 13'h008C, 11'h444, 1'b0},
        {1'b0, 13'h008C, 11'h222, 1'b0}, {1'b0, 13'h005A, 11'h111, 1'b1},
        {1'b0, 13'h01C2, 11'h222, 1'b0}, {1'b1, 13'h01C2, 11'h444, 1'b0}};
    logic [10:0] shl_vac [4] = '{11'h300, 11'h301, 11'h2F0, 11'h2EF};
    logic [10:0] shl_tgt [4] = '{11'h444, 11'h555, 11'h555, 11'h444};
    assign feats = {feedforward_en_o, light_load_filter_en_o, phase_shed_en_o, smart_fsw_en_o,
        smart_vout_en_o, pwm_sync_en_o, dither_en_o};
    always #(pfcsf_pkg::CLK_PERIOD_NS / 2) mclk_i = ~mclk_i;
    pfcsf_regs uut (.*);
    // ****************
    // Tasks
    // ****************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge mclk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
        @(negedge mclk_i) reg_wr_i = 1'b0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [15:0] exp);
        @(negedge mclk_i) {reg_addr_i, reg_rd_i} = {a, 1'b1};
        @(negedge mclk_i) reg_rd_i = 1'b0;
        check(16'(reg_rd_valid_o), 16'h0001);
        check(reg_rdata_o, exp);
    endtask
    task automatic step(input logic hl, input logic [12:0] pw, input logic [10:0] ac_input_voltage);
        @(negedge mclk_i) {high_line_i, input_power_i, ac_input_voltage_i} = {hl, pw, ac_input_voltage};
        repeat (3) @(negedge mclk_i);
    endtask
    task automatic ov_hit(input logic [1:0] act, input logic [10:0] sv);
        @(negedge mclk_i) {overvoltage_fault_action_i, vout_sense_i, ov_fault_i} = {act, sv, 1'b1};
        @(negedge mclk_i) ov_fault_i = 1'b0;
    endtask
    // Bounded wait: a missing start pulse ends the run
    task automatic sync_meas(input logic [15:0] dly, output int n);
        wr(pfcsf_pkg::ADDR_SYNC_DELAY, dly);
        n = 0;
        @(negedge mclk_i) sync_ref_i = 1'b1;
        while (pwm_sync_start_o !== 1'b1 && n < 200) begin
            @(negedge mclk_i);
            n++;
        end
        if (n >= 200) begin
            n_fail++;
            wrap_up();
        end
        @(negedge mclk_i) sync_ref_i = 1'b0;
        repeat (8) @(negedge mclk_i);
    endtask
    function automatic logic [15:0] rmask(input logic [15:0] a);
        if (a <= pfcsf_pkg::ADDR_SHL_THRESH) return 16'h07FF;
        if (a == pfcsf_pkg::ADDR_SYNC_DELAY) return 16'hFFFF;
        if (a == pfcsf_pkg::ADDR_FEATURES) return 16'h007F;
        if (a > pfcsf_pkg::ADDR_OV_HYS) return 16'h0000;
        return 16'h00FF;
    endfunction
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ****************
    // Sequence
    // ****************
    initial begin
        repeat (12) @(negedge mclk_i);
        rst_i = 1'b0;
        for (logic [15:0] a = pfcsf_pkg::ADDR_VOUT_LL_LIGHT; a <= 16'hFE51; a++) begin
            rdc(a, 16'h0000);
            wr(a, 16'hFFFF);
            rdc(a, rmask(a));
        end
        $display("register access test done");
        for (int i = 0; i < 5; i++) wr(pfcsf_pkg::ADDR_VOUT_LL_LIGHT + 16'(i), 16'h0111 * 16'(i + 1));
        wr(pfcsf_pkg::ADDR_SHL_THRESH, 16'h0300);
        wr(pfcsf_pkg::ADDR_SHL_HYS, 16'h0010);
        wr(pfcsf_pkg::ADDR_POWER_MODE_HYSTERESIS, 16'h0020);
        wr(pfcsf_pkg::ADDR_OV_HYS, 16'h0010);
        wr(pfcsf_pkg::ADDR_FEATURES, 16'h0004);
        foreach (rows[i]) begin
            step(rows[i].hl, rows[i].pw, 11'h000);
            check(16'(vout_target_o), 16'(rows[i].tgt));
            check(16'(low_power_mode_o), 16'(rows[i].lp));
        end
        foreach (shl_vac[i]) begin
            step(1'b1, 13'h01C2, shl_vac[i]);
            check(16'(vout_target_o), 16'(shl_tgt[i]));
        end
        wr(pfcsf_pkg::ADDR_FEATURES, 16'h0000);
        repeat (2) @(negedge mclk_i);
        check(16'(vout_target_o), 16'h00AB);
        $display("setpoint selection test done");
        for (int i = 0; i < 8; i++) begin
            wr(pfcsf_pkg::ADDR_FEATURES, 16'h0001 << i);
            check(16'(feats), (16'h0001 << i) & 16'h007F);
        end
        ov_hit(2'h2, 11'h210);
        check(16'(ov_shutdown_o), 16'h0001);
        step(1'b1, 13'h01C2, 11'h000);
        @(negedge mclk_i) vout_sense_i = 11'h1F0;
        repeat (2) @(negedge mclk_i);
        check(16'(ov_shutdown_o), 16'h0001);
        @(negedge mclk_i) vout_sense_i = 11'h1EF;
        repeat (2) @(negedge mclk_i);
        check(16'(ov_shutdown_o), 16'h0000);
        ov_hit(2'h1, 11'h1FF);
        check(16'(ov_shutdown_o), 16'h0001);
        @(negedge mclk_i);
        check(16'(ov_shutdown_o), 16'h0000);
        ov_hit(2'h0, 11'h210);
        check(16'(ov_shutdown_o), 16'h0000);
        $display("overvoltage test done");
        wr(pfcsf_pkg::ADDR_FEATURES, 16'h0002);
        sync_meas(16'h0000, n0);
        sync_meas(16'h0003, n3);
        check(16'(n3 - n0), 16'h0006);
        $display("sync delay test done");
        @(negedge mclk_i) rst_i = 1'b1;
        @(negedge mclk_i) check(16'(feats), 16'h0000);
        rst_i = 1'b0;
        rdc(pfcsf_pkg::ADDR_SYNC_DELAY, 16'h0000);
        $display("second reset test done");
        wrap_up();
    end
endmodule
`default_nettype wire

// ==== verif/pfcsf_regs_sva.sv ====
/* Port checker for the PFC setpoint and feature register bank.
   Assumes one clock mclk_i and the active-high asynchronous reset rst_i. */
`timescale 1ns/10ps
`default_nettype none
module pfcsf_regs_sva (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_rd_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic reg_rd_valid_o,
    input wire logic [12:0] input_power_i,
    input wire logic [12:0] low_power_threshold_i,
    input wire logic [12:0] high_power_threshold_i,
    input wire logic [10:0] vout_command_i,
    input wire logic [10:0] vout_target_o,
    input wire logic low_power_mode_o,
    input wire logic super_high_line_o,
    input wire logic ov_fault_i,
    input wire logic [1:0] overvoltage_fault_action_i,
    input wire logic [10:0] vout_sense_i,
    input wire logic [10:0] overvoltage_fault_limit_i,
    input wire logic ov_shutdown_o,
    input wire logic smart_vout_en_o,
    input wire logic pwm_sync_en_o,
    input wire logic pwm_sync_start_o
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic feat_wr;
    assign feat_wr = reg_wr_i && reg_addr_i == pfcsf_pkg::ADDR_FEATURES;
    sequence s_rd_req;
        reg_rd_i ##1 !reg_rd_i;
    endsequence
    sequence s_rd_done;
        reg_rd_valid_o ##1 !reg_rd_valid_o;
    endsequence
    chk_rd_pulse: assert property (s_rd_req |-> s_rd_done)
        else $error("read valid pulse");
    chk_resv_zero: assert property (reg_rd_valid_o
        && $past(reg_addr_i) != pfcsf_pkg::ADDR_SYNC_DELAY |-> reg_rdata_o[15:11] == 5'h00)
        else $error("reserved bits set");
    chk_feat_set: assert property (feat_wr && reg_wdata_i[2] && reg_wdata_i[1]
        |=> smart_vout_en_o && pwm_sync_en_o) else $error("feature not set");
    chk_smart_clear: assert property (feat_wr && !reg_wdata_i[2] |=> !smart_vout_en_o)
        else $error("smart not cleared");
    chk_smart_off: assert property (!smart_vout_en_o |=> vout_target_o == $past(vout_command_i)
        && !low_power_mode_o && !super_high_line_o) else $error("target not nominal");
    chk_low_enter: assert property (smart_vout_en_o && !reg_wr_i && !super_high_line_o
        && input_power_i < low_power_threshold_i |=> low_power_mode_o)
        else $error("low power missed");
    chk_high_enter: assert property (smart_vout_en_o && !reg_wr_i
        && input_power_i > high_power_threshold_i && input_power_i >= low_power_threshold_i
        |=> !low_power_mode_o) else $error("high power missed");
    chk_ov_set: assert property (ov_fault_i && overvoltage_fault_action_i != 2'h0
        |=> ov_shutdown_o) else $error("shutdown missed");
    chk_ov_ignore: assert property (!ov_shutdown_o && overvoltage_fault_action_i == 2'h0
        |=> !ov_shutdown_o) else $error("shutdown on ignore");
    chk_ov_hold: assert property (ov_shutdown_o
        && vout_sense_i >= overvoltage_fault_limit_i |=> ov_shutdown_o)
        else $error("early release");
    chk_sync_gate: assert property (!pwm_sync_en_o |=> !pwm_sync_start_o)
        else $error("start while off");
    chk_sync_single: assert property (pwm_sync_start_o |=> !pwm_sync_start_o)
        else $error("start too long");
endmodule
bind pfcsf_regs pfcsf_regs_sva u_chk (.*);
`default_nettype wire
